/* rtl/mces_pkg.sv */
// Package: constants and types of the context and endianness selector
`default_nettype none
package mces_pkg;
    localparam int CTX_ARCH_W   = 16;
    localparam int CTX_IMPL_W   = 13;
    localparam int VPN_W        = 51;
    localparam int TSB_LOG2_MIN = 9;
    localparam int TSB_LOG2_MAX = 24;
    localparam int TSB_LOG2_W   = 5;
    localparam int TAG_CTX_LSB  = 48;
    localparam int TAG_VA_W     = 42;
    localparam int DATA_IE_BIT  = 59;
    localparam int DATA_EP_BIT  = 7;
    localparam int DATA_W_BIT   = 6;
    localparam int DATA_V_BIT   = 63;
    localparam int TL_W         = 3;
    localparam logic [2:0] TL_ZERO     = 3'h0;
    localparam logic [2:0] TL_PRIV_MAX = 3'h2;
    localparam logic [15:0] CTX_NUCLEUS = 16'h0000;

    typedef enum logic [2:0] {
        MCES_SP_IMPLICIT  = 3'h0,
        MCES_SP_PRIMARY   = 3'h1,
        MCES_SP_SECONDARY = 3'h2,
        MCES_SP_AIU_PRI   = 3'h3,
        MCES_SP_AIU_SEC   = 3'h4,
        MCES_SP_NUCLEUS   = 3'h5,
        MCES_SP_BYPASS    = 3'h6
    } mces_space_e;

    typedef enum logic [1:0] {
        MCES_CTX_PRIMARY   = 2'h0,
        MCES_CTX_SECONDARY = 2'h1,
        MCES_CTX_NUCLEUS   = 2'h2,
        MCES_CTX_NONE      = 2'h3
    } mces_ctx_e;

    typedef enum logic [1:0] {
        MCES_ST_IDLE = 2'h0,
        MCES_ST_READ = 2'h1,
        MCES_ST_DONE = 2'h2
    } mces_state_e;
endpackage : mces_pkg
`default_nettype wire

/* rtl/mces_ctx_if.sv */
// Interface: context identifier registers shared between modules
`default_nettype none
interface mces_ctx_if;
    import mces_pkg::*;
    logic [CTX_ARCH_W-1:0] pri0;
    logic [CTX_ARCH_W-1:0] pri1;
    logic [CTX_ARCH_W-1:0] sec0;
    logic [CTX_ARCH_W-1:0] sec1;
    modport owner (output pri0, output pri1, output sec0, output sec1);
    modport user  (input pri0, input pri1, input sec0, input sec1);
endinterface : mces_ctx_if
`default_nettype wire

/* rtl/mces_ctx_regs.sv */
// Context identifier register bank with implemented-width masking
`default_nettype none
module mces_ctx_regs
    import mces_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // Write port
    input  wire logic                  wr_en,
    input  wire logic [1:0]            wr_sel,
    input  wire logic [CTX_ARCH_W-1:0] wr_data,
    // Register values
    mces_ctx_if.owner                  ctx
);
    typedef struct packed {
        logic [3:0][CTX_ARCH_W-1:0] id;
    } mces_regs_s;

    localparam logic [CTX_ARCH_W-1:0] IMPL_MASK =
        CTX_ARCH_W'((32'h1 << CTX_IMPL_W) - 32'h1);

    mces_regs_s st_r;
    mces_regs_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (wr_en) begin
            st_nxt.id[wr_sel] = wr_data & IMPL_MASK;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ctx.pri0 = st_r.id[0];
    assign ctx.pri1 = st_r.id[1];
    assign ctx.sec0 = st_r.id[2];
    assign ctx.sec1 = st_r.id[3];

    AST_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_r.id[0] & ~IMPL_MASK) == '0 && (st_r.id[2] & ~IMPL_MASK) == '0)
        else $error("unimplemented context bits not zero");
endmodule : mces_ctx_regs
`default_nettype wire

/* rtl/mces_entry_mem.sv */
// Entry buffer memory: tag and data words per line, registered read
`default_nettype none
module mces_entry_mem
    import mces_pkg::*;
#(
    parameter int LOG2_DEPTH = TSB_LOG2_MIN
) (
    // Clock
    input  wire logic                  ref_clk,
    // Write port
    input  wire logic                  wr_en,
    input  wire logic [LOG2_DEPTH-1:0] wr_idx,
    input  wire logic [63:0]           wr_tag,
    input  wire logic [63:0]           wr_data,
    // Read port
    input  wire logic                  rd_en,
    input  wire logic [LOG2_DEPTH-1:0] rd_idx,
    output logic      [63:0]           rd_tag,
    output logic      [63:0]           rd_data
);
    logic [127:0] mem [0:(1<<LOG2_DEPTH)-1];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_idx] <= {wr_tag, wr_data};
        end
        if (rd_en) begin
            {rd_tag, rd_data} <= mem[rd_idx];
        end
    end
endmodule : mces_entry_mem
`default_nettype wire

/* rtl/mces_select.sv */
// Top: context selection, endianness, entry buffer lookup, permissions
`default_nettype none
module mces_select
    import mces_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // Context register writes
    input  wire logic                  ctx_wr_en,
    input  wire logic [1:0]            ctx_wr_sel,
    input  wire logic [CTX_ARCH_W-1:0] ctx_wr_data,
    // Buffer configuration and fill
    input  wire logic [TSB_LOG2_W-1:0] tsb_log2,
    input  wire logic                  ent_wr_en,
    input  wire logic [VPN_W-1:0]      ent_wr_vpn,
    input  wire logic [63:0]           ent_wr_tag,
    input  wire logic [63:0]           ent_wr_data,
    // Access request
    input  wire logic                  req_valid,
    input  wire logic                  req_fetch,
    input  wire logic                  req_read,
    input  wire logic                  req_write,
    input  wire logic [2:0]            req_space,
    input  wire logic                  req_space_little,
    input  wire logic [TL_W-1:0]       trap_level,
    input  wire logic                  privilege_state_bit,
    input  wire logic                  current_little_endian_bit,
    input  wire logic [VPN_W-1:0]      req_vpn,
    // Result
    output logic                       rsp_valid,
    output logic                       rsp_illegal,
    output logic [1:0]                 rsp_ctx_sel,
    output logic [CTX_ARCH_W-1:0]      rsp_ctx_id,
    output logic                       rsp_hit,
    output logic                       rsp_little,
    output logic                       rsp_perm_fault,
    output logic [63:0]                rsp_entry_data,
    output logic [CTX_ARCH_W-1:0]      ctx_pri0_rd,
    output logic [CTX_ARCH_W-1:0]      ctx_sec0_rd
);
    localparam int IDX_W = TSB_LOG2_MAX;

    // ==========================================================
    // Context registers
    mces_ctx_if ctx_bus ();

    mces_ctx_regs u_regs (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .wr_en   (ctx_wr_en),
        .wr_sel  (ctx_wr_sel),
        .wr_data (ctx_wr_data),
        .ctx     (ctx_bus.owner)
    );

    // ==========================================================
    // Entry buffer memory
    logic [IDX_W-1:0] wr_idx;
    logic [IDX_W-1:0] rd_idx;
    logic [63:0]      mem_tag;
    logic [63:0]      mem_data;

    // Buffer size clamped to 512 .. 16M entries
    function automatic logic [IDX_W-1:0] idx_of(
        input logic [VPN_W-1:0]      vpn,
        input logic [TSB_LOG2_W-1:0] n
    );
        logic [IDX_W-1:0] mask;
        logic [TSB_LOG2_W-1:0] nn;
        nn = n;
        if (nn < TSB_LOG2_W'(TSB_LOG2_MIN)) nn = TSB_LOG2_W'(TSB_LOG2_MIN);
        if (nn > TSB_LOG2_W'(TSB_LOG2_MAX)) nn = TSB_LOG2_W'(TSB_LOG2_MAX);
        mask = IDX_W'((32'h1 << nn) - 32'h1);
        return vpn[IDX_W-1:0] & mask;
    endfunction : idx_of

    assign wr_idx = idx_of(ent_wr_vpn, tsb_log2);
    assign rd_idx = idx_of(req_vpn, tsb_log2);

    mces_entry_mem #(.LOG2_DEPTH(IDX_W)) u_mem (
        .ref_clk (ref_clk),
        .wr_en   (ent_wr_en),
        .wr_idx  (wr_idx),
        .wr_tag  (ent_wr_tag),
        .wr_data (ent_wr_data),
        .rd_en   (req_valid),
        .rd_idx  (rd_idx),
        .rd_tag  (mem_tag),
        .rd_data (mem_data)
    );

    // ==========================================================
    // Context selection
    mces_ctx_e  sel_ctx;
    logic       sel_illegal;
    logic       bypass;
    logic       priv_ok;
    logic       tl_zero;

    always_comb begin
        tl_zero = (trap_level == TL_ZERO);
        priv_ok = privilege_state_bit ? (trap_level <= TL_PRIV_MAX)
                                      : tl_zero;
        bypass  = (req_space == MCES_SP_BYPASS);
        sel_ctx = MCES_CTX_NONE;
        if (req_fetch) begin
            sel_ctx = tl_zero ? MCES_CTX_PRIMARY
                              : MCES_CTX_NUCLEUS;
        end else begin
            case (req_space)
                MCES_SP_IMPLICIT:  sel_ctx = tl_zero ? MCES_CTX_PRIMARY
                                                     : MCES_CTX_NUCLEUS;
                MCES_SP_PRIMARY:   sel_ctx = MCES_CTX_PRIMARY;
                MCES_SP_SECONDARY: sel_ctx = MCES_CTX_SECONDARY;
                MCES_SP_AIU_PRI:   sel_ctx = privilege_state_bit
                                   ? MCES_CTX_PRIMARY : MCES_CTX_NONE;
                MCES_SP_AIU_SEC:   sel_ctx = privilege_state_bit
                                   ? MCES_CTX_SECONDARY : MCES_CTX_NONE;
                MCES_SP_NUCLEUS:   sel_ctx = privilege_state_bit
                                   ? MCES_CTX_NUCLEUS : MCES_CTX_NONE;
                default:           sel_ctx = MCES_CTX_NONE;
            endcase
        end
        sel_illegal = !priv_ok ||
                      (!bypass && sel_ctx == MCES_CTX_NONE);
    end

    // ==========================================================
    // Pipeline state
    typedef struct packed {
        mces_state_e           state;
        logic                  illegal;
        mces_ctx_e             ctx;
        logic                  bypass;
        logic                  little;
        logic                  fetch;
        logic                  rd;
        logic                  wr;
        logic [VPN_W-1:0]      vpn;
        logic                  o_valid;
        logic                  o_illegal;
        logic [1:0]            o_ctx;
        logic [CTX_ARCH_W-1:0] o_id;
        logic                  o_hit;
        logic                  o_little;
        logic                  o_fault;
        logic [63:0]           o_data;
        logic [CTX_ARCH_W-1:0] rb_pri0;
        logic [CTX_ARCH_W-1:0] rb_sec0;
    } mces_top_s;

    mces_top_s st_r;
    mces_top_s st_nxt;

    logic                  tag_ctx_hit;
    logic                  tag_va_hit;
    logic                  hit;
    logic                  perm_ok;
    logic [CTX_ARCH_W-1:0] tag_ctx;
    logic [CTX_ARCH_W-1:0] emit_id;

    always_comb begin
        tag_ctx = mem_tag[TAG_CTX_LSB +: CTX_ARCH_W];
        case (st_r.ctx)
            MCES_CTX_PRIMARY:   tag_ctx_hit = (tag_ctx == ctx_bus.pri0) ||
                                              (tag_ctx == ctx_bus.pri1);
            MCES_CTX_SECONDARY: tag_ctx_hit = (tag_ctx == ctx_bus.sec0) ||
                                              (tag_ctx == ctx_bus.sec1);
            MCES_CTX_NUCLEUS:   tag_ctx_hit = (tag_ctx == CTX_NUCLEUS);
            default:            tag_ctx_hit = 1'b0;
        endcase
        tag_va_hit = mem_tag[TAG_VA_W-1:0] == st_r.vpn[VPN_W-1 -: TAG_VA_W];
        hit = tag_ctx_hit && tag_va_hit && !st_r.bypass
              && mem_data[DATA_V_BIT];
        perm_ok = (!st_r.fetch || mem_data[DATA_EP_BIT])
                  && (!st_r.wr || mem_data[DATA_W_BIT]);
        case (st_r.ctx)
            MCES_CTX_PRIMARY:   emit_id = ctx_bus.pri0;
            MCES_CTX_SECONDARY: emit_id = ctx_bus.sec0;
            default:            emit_id = CTX_NUCLEUS;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.o_valid = 1'b0;
        st_nxt.rb_pri0 = ctx_bus.pri0;
        st_nxt.rb_sec0 = ctx_bus.sec0;
        case (st_r.state)
            MCES_ST_IDLE: begin
                if (req_valid) begin
                    st_nxt.state   = MCES_ST_READ;
                    st_nxt.illegal = sel_illegal;
                    st_nxt.ctx     = sel_ctx;
                    st_nxt.bypass  = bypass && !req_fetch;
                    st_nxt.little  = req_space_little
                                     || current_little_endian_bit;
                    st_nxt.fetch   = req_fetch;
                    st_nxt.rd      = req_read;
                    st_nxt.wr      = req_write;
                    st_nxt.vpn     = req_vpn;
                end
            end
            MCES_ST_READ: begin
                st_nxt.state     = MCES_ST_IDLE;
                st_nxt.o_valid   = 1'b1;
                st_nxt.o_illegal = st_r.illegal;
                st_nxt.o_ctx     = st_r.illegal ? MCES_CTX_NONE
                                                : st_r.ctx;
                st_nxt.o_id      = st_r.illegal ? CTX_NUCLEUS : emit_id;
                st_nxt.o_hit     = hit && !st_r.illegal;
                st_nxt.o_data    = (hit && !st_r.illegal) ? mem_data
                                                          : '0;
                st_nxt.o_fault   = hit && !st_r.illegal && !perm_ok;
                if (st_r.bypass) begin
                    st_nxt.o_little = 1'b0;
                end else begin
                    st_nxt.o_little = st_r.little
                                      ^ (hit && mem_data[DATA_IE_BIT]);
                end
            end
            default: st_nxt.state = MCES_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign rsp_valid      = st_r.o_valid;
    assign rsp_illegal    = st_r.o_illegal;
    assign rsp_ctx_sel    = st_r.o_ctx;
    assign rsp_ctx_id     = st_r.o_id;
    assign rsp_hit        = st_r.o_hit;
    assign rsp_little     = st_r.o_little;
    assign rsp_perm_fault = st_r.o_fault;
    assign rsp_entry_data = st_r.o_data;

    assign ctx_pri0_rd    = st_r.rb_pri0;
    assign ctx_sec0_rd    = st_r.rb_sec0;

    // ==========================================================
    // Checks
    AST_FETCH_NO_SEC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_r.state == MCES_ST_READ && st_r.fetch |=>
        rsp_ctx_sel != MCES_CTX_SECONDARY)
        else $error("secondary context used for fetch");
    AST_FETCH_CTX: assert property (@(posedge ref_clk) disable iff (!rst_n)
        req_valid && st_r.state == MCES_ST_IDLE && req_fetch
        && trap_level == TL_ZERO
        |=> ##1 rsp_valid && rsp_ctx_sel == MCES_CTX_PRIMARY)
        else $error("fetch at level zero not primary");
    AST_IMPL_NUC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        req_valid && st_r.state == MCES_ST_IDLE && !req_fetch
        && req_space == MCES_SP_IMPLICIT && privilege_state_bit
        && trap_level != TL_ZERO && trap_level <= TL_PRIV_MAX
        |=> ##1 rsp_ctx_sel == MCES_CTX_NUCLEUS && rsp_ctx_id == '0)
        else $error("implicit data above level zero not nucleus");
    AST_USER_SEC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        req_valid && st_r.state == MCES_ST_IDLE && !req_fetch
        && req_space == MCES_SP_SECONDARY && !privilege_state_bit
        && trap_level == TL_ZERO
        |=> ##1 rsp_ctx_sel == MCES_CTX_SECONDARY)
        else $error("secondary identifier not secondary");
    AST_USER_NUC_ILL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        req_valid && st_r.state == MCES_ST_IDLE && !req_fetch
        && req_space == MCES_SP_NUCLEUS && !privilege_state_bit
        |=> ##1 rsp_illegal && rsp_ctx_sel == MCES_CTX_NONE)
        else $error("user nucleus access not illegal");
    AST_TL_ILLEGAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        req_valid && st_r.state == MCES_ST_IDLE && !privilege_state_bit
        && trap_level != TL_ZERO |=> ##1 rsp_valid && rsp_illegal)
        else $error("user above level zero not illegal");
    AST_BYPASS_BIG: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_r.state == MCES_ST_READ && st_r.bypass |=> !rsp_little)
        else $error("bypass access not big-endian");
    AST_DATA_ON_HIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rsp_valid && !rsp_hit |-> rsp_entry_data == '0 && !rsp_perm_fault)
        else $error("entry data used without hit");
    AST_IE_FLIP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_r.state == MCES_ST_READ && !st_r.bypass && hit
        |=> rsp_little == ($past(st_r.little) ^ $past(mem_data[DATA_IE_BIT])))
        else $error("invert bit not applied");
    AST_FETCH_NUC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        req_valid && st_r.state == MCES_ST_IDLE && req_fetch
        && privilege_state_bit && trap_level != TL_ZERO
        && trap_level <= TL_PRIV_MAX
        |=> ##1 rsp_ctx_sel == MCES_CTX_NUCLEUS)
        else $error("fetch above level zero not nucleus");
    AST_PRIV_AIU_SEC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        req_valid && st_r.state == MCES_ST_IDLE && !req_fetch
        && req_space == MCES_SP_AIU_SEC && privilege_state_bit
        && trap_level <= TL_PRIV_MAX
        |=> ##1 rsp_ctx_sel == MCES_CTX_SECONDARY)
        else $error("as-user secondary not secondary");
    AST_NUC_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rsp_valid && rsp_ctx_sel == MCES_CTX_NUCLEUS |-> rsp_ctx_id == '0)
        else $error("nucleus identifier not zero");
    AST_ILL_NO_CTX: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rsp_valid && rsp_illegal |-> rsp_ctx_sel == MCES_CTX_NONE && !rsp_hit)
        else $error("illegal access emitted a context");
    AST_WR_PERM: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_r.state == MCES_ST_READ && hit && !st_r.illegal && st_r.wr
        && !mem_data[DATA_W_BIT] |=> rsp_perm_fault)
        else $error("write without permission not faulted");
    AST_EXEC_PERM: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_r.state == MCES_ST_READ && hit && !st_r.illegal && st_r.fetch
        && !mem_data[DATA_EP_BIT] |=> rsp_perm_fault)
        else $error("fetch without execute not faulted");
    AST_MISS_NO_FLIP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_r.state == MCES_ST_READ && !st_r.bypass && !hit
        |=> rsp_little == $past(st_r.little))
        else $error("endianness flipped on a miss");
    AST_CLASS_HIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_r.state == MCES_ST_READ && st_r.ctx == MCES_CTX_PRIMARY
        && !st_r.illegal && mem_data[DATA_V_BIT] && tag_va_hit
        && mem_tag[TAG_CTX_LSB +: CTX_ARCH_W] == ctx_bus.pri1
        |=> rsp_hit)
        else $error("second primary register did not hit");
endmodule : mces_select
`default_nettype wire

/* verification/mces_iu_model.sv */
// Integer unit model: issues one access and waits for its answer
`default_nettype none
module mces_iu_model
    import mces_pkg::*;
(
    // Clock and answer
    input  wire logic        ref_clk,
    input  wire logic        rsp_valid,
    // Access request
    output logic             req_valid,
    output logic             req_fetch,
    output logic             req_read,
    output logic             req_write,
    output logic [2:0]       req_space,
    output logic             req_space_little,
    output logic [TL_W-1:0]  trap_level,
    output logic             privilege_state_bit,
    output logic             current_little_endian_bit,
    output logic [VPN_W-1:0] req_vpn
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {req_valid, req_fetch, req_read, req_write, req_space} = '0;
        {req_space_little, trap_level, privilege_state_bit} = '0;
        {current_little_endian_bit, req_vpn} = '0;
    end

    // One access; fields held until the answer arrives
    task automatic issue(input logic [11:0] k, input logic [VPN_W-1:0] v,
                         output bit ok);
        int n;
        @(posedge ref_clk);
        req_valid <= 1'b1;
        {req_fetch, req_read, req_write, req_space, req_space_little,
         trap_level, privilege_state_bit, current_little_endian_bit} <= k;
        req_vpn <= v;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        ok = 1'b0;
        for (n = 0; n < 6 && !ok; n++) begin
            @(negedge ref_clk);
            ok = (rsp_valid === 1'b1);
        end
        // Released address and space fields show the inverse of their last value
        @(posedge ref_clk);
        req_vpn <= ~v;
        req_space <= ~k[8:6];
    endtask : issue
endmodule : mces_iu_model
`default_nettype wire

/* verification/mces_select_test.sv */
// Testbench: context selection, endianness, lookup and permissions
`default_nettype none
module mces_select_test
    import mces_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] FE = 3'b100, RD = 3'b010, WR = 3'b001;
    localparam logic [2:0] AT = 3'b011;
    localparam mces_ctx_e PRI = MCES_CTX_PRIMARY, SEC = MCES_CTX_SECONDARY;
    localparam mces_ctx_e NUC = MCES_CTX_NUCLEUS, NON = MCES_CTX_NONE;
    localparam logic [VPN_W-1:0] VA = {42'h3, 9'h005}, VB = {42'h7, 9'h1FF};
    localparam logic [VPN_W-1:0] VC = {42'h4, 9'h005}, VZ = '0;
    localparam logic [63:0] DA = 64'h8800_0000_1234_5000;
    localparam logic [63:0] DB = 64'h8000_0000_0ABC_00C0;
    // ==========================================================
    // Signals
    logic ref_clk, rst_n, ctx_wr_en, ent_wr_en;
    logic [1:0] ctx_wr_sel;
    logic [CTX_ARCH_W-1:0] ctx_wr_data, rsp_ctx_id, ctx_pri0_rd, ctx_sec0_rd;
    logic [TSB_LOG2_W-1:0] tsb_log2;
    logic [VPN_W-1:0] ent_wr_vpn, req_vpn;
    logic [63:0] ent_wr_tag, ent_wr_data, rsp_entry_data;
    logic req_valid, req_fetch, req_read, req_write, req_space_little;
    logic [2:0] req_space;
    logic [TL_W-1:0] trap_level;
    logic privilege_state_bit, current_little_endian_bit;
    logic rsp_valid, rsp_illegal, rsp_hit, rsp_little, rsp_perm_fault;
    logic [1:0] rsp_ctx_sel;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    // ==========================================================
    // Design and integer unit model
    mces_select dut (.ref_clk, .rst_n, .ctx_wr_en, .ctx_wr_sel, .ctx_wr_data,
        .tsb_log2, .ent_wr_en, .ent_wr_vpn, .ent_wr_tag, .ent_wr_data,
        .req_valid, .req_fetch, .req_read, .req_write, .req_space,
        .req_space_little, .trap_level, .privilege_state_bit,
        .current_little_endian_bit, .req_vpn, .rsp_valid, .rsp_illegal,
        .rsp_ctx_sel, .rsp_ctx_id, .rsp_hit, .rsp_little, .rsp_perm_fault,
        .rsp_entry_data, .ctx_pri0_rd, .ctx_sec0_rd);
    mces_iu_model iu (.ref_clk, .rsp_valid, .req_valid, .req_fetch,
        .req_read, .req_write, .req_space, .req_space_little, .trap_level,
        .privilege_state_bit, .current_little_endian_bit, .req_vpn);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            conclude();
        end
    end
    // ==========================================================
    // Tasks
    task automatic conclude();
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic chk(input string s, input logic [63:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk

    task automatic wr_ctx(input logic [1:0] s, input logic [15:0] d);
        @(posedge ref_clk);
        ctx_wr_en <= 1'b1;
        ctx_wr_sel <= s;
        ctx_wr_data <= d;
        @(posedge ref_clk);
        ctx_wr_en <= 1'b0;
    endtask : wr_ctx

    task automatic wr_ent(input logic [VPN_W-1:0] v, input logic [63:0] t, d);
        @(posedge ref_clk);
        ent_wr_en <= 1'b1;
        ent_wr_vpn <= v;
        ent_wr_tag <= t;
        ent_wr_data <= d;
        @(posedge ref_clk);
        ent_wr_en <= 1'b0;
    endtask : wr_ent

    task automatic req(input logic [11:0] k, input logic [VPN_W-1:0] v);
        bit ok;
        iu.issue(k, v, ok);
        if (!ok) begin
            bad_count++;
            conclude();
        end
    endtask : req

    task automatic ctx_case(input logic [2:0] a, sp, tl, input logic pv,
                            input mces_ctx_e e, input logic il);
        logic [15:0] id;
        id = e == PRI ? 16'h1FFF : e == SEC ? 16'h0123 : CTX_NUCLEUS;
        req({a, sp, 1'b0, tl, pv, 1'b0}, VZ);
        chk("illegal", rsp_illegal, il);
        chk("ctx_sel", rsp_ctx_sel, e);
        if (!il)
            chk("ctx_id", rsp_ctx_id, id);
    endtask : ctx_case

    // Flags: space little, trap level, privilege, little bit; hit little fault
    task automatic acc(input logic [2:0] a, sp, input logic [5:0] f,
                       input logic [VPN_W-1:0] v, input logic [2:0] e,
                       input logic [63:0] d);
        req({a, sp, f}, v);
        chk("hit", rsp_hit, e[2]);
        chk("little", rsp_little, e[1]);
        chk("data", rsp_entry_data, d);
        if (e[2])
            chk("perm", rsp_perm_fault, e[0]);
    endtask : acc
    // ==========================================================
    // Main sequence
    initial begin
        {ctx_wr_en, ent_wr_en, ctx_wr_sel} = '0;
        {ctx_wr_data, ent_wr_vpn, ent_wr_tag, ent_wr_data} = '0;
        tsb_log2 = 5'h09;
        rst_n = 1'b0;
        repeat (12) @(posedge ref_clk);
        chk("pri0_rd", ctx_pri0_rd, 64'h0);
        rst_n <= 1'b1;
        wr_ctx(2'h0, 16'hFFFF);
        wr_ctx(2'h2, 16'hE123);
        wr_ctx(2'h1, 16'h0042);
        wr_ent(VZ, 64'h0, 64'h0);
        wr_ent(VA, {16'h0042, 6'h0, 42'h3}, DA);
        wr_ent(VB, {16'h0000, 6'h0, 42'h7}, DB);
        @(negedge ref_clk);
        chk("pri0_rd", ctx_pri0_rd, 64'h1FFF);
        chk("sec0_rd", ctx_sec0_rd, 64'h0123);
        ctx_case(FE, 3'h0, 3'h0, 1'b0, PRI, 1'b0);
        ctx_case(FE, 3'h0, 3'h1, 1'b1, NUC, 1'b0);
        ctx_case(RD, 3'h0, 3'h0, 1'b0, PRI, 1'b0);
        ctx_case(RD, 3'h0, 3'h2, 1'b1, NUC, 1'b0);
        ctx_case(RD, 3'h1, 3'h0, 1'b0, PRI, 1'b0);
        ctx_case(WR, 3'h2, 3'h0, 1'b0, SEC, 1'b0);
        ctx_case(RD, 3'h1, 3'h0, 1'b1, PRI, 1'b0);
        ctx_case(RD, 3'h3, 3'h1, 1'b1, PRI, 1'b0);
        ctx_case(AT, 3'h2, 3'h0, 1'b1, SEC, 1'b0);
        ctx_case(RD, 3'h4, 3'h2, 1'b1, SEC, 1'b0);
        ctx_case(WR, 3'h5, 3'h0, 1'b1, NUC, 1'b0);
        ctx_case(RD, 3'h0, 3'h1, 1'b0, NON, 1'b1);
        ctx_case(RD, 3'h1, 3'h3, 1'b1, NON, 1'b1);
        ctx_case(RD, 3'h5, 3'h0, 1'b0, NON, 1'b1);
        ctx_case(RD, 3'h7, 3'h0, 1'b1, NON, 1'b1);
        acc(RD, 3'h1, 6'h00, VA, 3'h6, DA);
        acc(RD, 3'h1, 6'h20, VA, 3'h4, DA);
        acc(AT, 3'h1, 6'h00, VA, 3'h7, DA);
        acc(FE, 3'h0, 6'h00, VA, 3'h7, DA);
        acc(RD, 3'h2, 6'h00, VA, 3'h0, 64'h0);
        acc(RD, 3'h1, 6'h00, VC, 3'h0, 64'h0);
        acc(FE, 3'h0, 6'h06, VB, 3'h4, DB);
        acc(WR, 3'h5, 6'h03, VB, 3'h6, DB);
        req({RD, 3'h6, 1'b1, 3'h0, 1'b1, 1'b1}, VA);
        chk("bypass_little", rsp_little, 64'h0);
        wr_ctx(2'h0, 16'h0042);
        acc(RD, 3'h1, 6'h02, VA, 3'h6, DA);
        chk("pri0_rd", ctx_pri0_rd, 64'h0042);
        @(posedge ref_clk);
        tsb_log2 <= 5'h03;
        acc(RD, 3'h1, 6'h00, VA, 3'h6, DA);
        conclude();
    end
endmodule : mces_select_test
`default_nettype wire
